//--- design/opc_pkg.sv
/*
  Constants for the output pin and configuration register block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 250 MHz core clock and registers reached by the serial
  port core through a byte-wide register access port.
*/
package opc_pkg;
  // Register offsets
  localparam logic [7:0] OFS_CONTROL_A = 8'h0f;
  localparam logic [7:0] OFS_CONTROL_B = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h11;
  localparam logic [7:0] OFS_CLOCK_SYNC = 8'h12;
  // Typical defaults; the real ones arrive from OTP at reset
  localparam logic [7:0] RST_CONTROL_A = 8'haa;
  localparam logic [7:0] RST_CONTROL_B = 8'h0a;
  localparam logic [7:0] RST_CONFIG = 8'h3c;
  localparam logic [7:0] RST_CLOCK_SYNC = 8'h02;
  // Control A fields
  localparam int B_DRIVE_TYPE = 7;
  localparam int B_GATE_HI = 6;
  localparam int B_GATE_LO = 5;
  localparam int B_LEVEL = 4;
  localparam int A_DRIVE_TYPE = 3;
  localparam int A_GATE_HI = 2;
  localparam int A_GATE_LO = 1;
  localparam int A_LEVEL = 0;
  // Control B fields
  localparam int CLOCK_PIN_FUNC = 5;
  localparam int PG_PIN_FUNC = 4;
  localparam int C_DRIVE_TYPE = 3;
  localparam int C_GATE_HI = 2;
  localparam int C_GATE_LO = 1;
  localparam int C_LEVEL = 0;
  // Configuration fields
  localparam int STARTUP_RANGE = 7;
  localparam int SHUTDOWN_RANGE = 6;
  localparam int CLOCK_PD = 5;
  localparam int PD_ENABLE_THREE = 4;
  localparam int PD_ENABLE_TWO = 3;
  localparam int PD_ENABLE_ONE = 2;
  localparam int THERMAL_LEVEL = 1;
  localparam int SPREAD_ENABLE = 0;
  // Clock sync fields
  localparam int LOOP_ENABLE = 6;
  localparam int FRAC_ENABLE = 5;
  localparam int FREQ_HI = 4;
  localparam int FREQ_LO = 0;
  // Thermal warning thresholds in degrees C
  localparam logic [7:0] THERMAL_LOW_C = 8'h7d;
  localparam logic [7:0] THERMAL_HIGH_C = 8'h8c;
  // Timing
  localparam int CLOCK_MHZ = 250;
  localparam int DELAY_STEP_US = 500;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLOCK_MHZ;
  localparam int CLOCK_LOSS_NS = 2000;
  localparam int CLOCK_LOSS_CYCLES = CLOCK_LOSS_NS * CLOCK_MHZ / 1000;
  localparam int SYNC_LATENCY = 3;
  // Delay sequencer states
  typedef enum logic [1:0] {
    SEQ_OFF, SEQ_RISING, SEQ_ON, SEQ_FALLING
  } opc_seq_e;
endpackage : opc_pkg

//--- design/opc_pin_cell.sv
/*
  One configurable output pin cell: gate selection, level, drive type
  and alternate function. Assumes enable inputs are already
  synchronised to clock; pin output and enable come from flip-flops.
*/
`timescale 1ns/1ps
module opc_pin_cell (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration
  input wire logic [1:0] gate_select,
  input wire logic level,
  input wire logic open_drain,
  input wire logic func_is_output,
  input wire logic alt_drive,
  input wire logic alt_level,
  // Synchronised enable inputs, bit 0 is enable one
  input wire logic [2:0] enables,
  // Pin
  output logic pin_out,
  output logic pin_oe
);
  import opc_pkg::*;
  logic gated;
  logic want;
  logic drive;

  // Level ANDed with the chosen enable input, code zero is ungated
  always_comb begin
    unique case (gate_select)
      2'h0: gated = level;
      2'h1: gated = level & enables[0];
      2'h2: gated = level & enables[1];
      2'h3: gated = level & enables[2];
    endcase
  end

  // Alternate function either drives its own level or releases the pin
  assign want = func_is_output ? gated : alt_level;
  assign drive = func_is_output | alt_drive;

  // Open-drain only pulls low; a high level releases the pin
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (!drive) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else if (open_drain) begin
      pin_out <= 1'b0;
      pin_oe <= ~want;
    end else begin
      pin_out <= want;
      pin_oe <= 1'b1;
    end
  end
endmodule : opc_pin_cell

//--- design/opc_regs.sv
/*
  Output pin and configuration register bank: four byte registers,
  three output pin cells, pull-down and converter configuration,
  thermal warning compare, external clock detection and a delayed
  enable sequencer. Assumes the serial port core presents byte
  register accesses on the same clock and that OTP defaults are
  stable whenever reset is asserted.
*/
`timescale 1ns/1ps
module opc_regs #(
  parameter int STEP_CYCLES = opc_pkg::DELAY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register access from the serial port core
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_address,
  input wire logic [7:0] reg_write_data,
  output logic [7:0] reg_read_data,
  output logic reg_read_valid,
  // One-time-programmable defaults
  input wire logic [7:0] otp_control_a,
  input wire logic [7:0] otp_control_b,
  input wire logic [7:0] otp_config,
  input wire logic [7:0] otp_clock_sync,
  // Enable and clock pins
  input wire logic enable_input_one,
  input wire logic enable_input_two,
  input wire logic enable_input_three,
  input wire logic external_clock_input,
  // Internal power-good and temperature
  input wire logic power_good_b,
  input wire logic [7:0] die_temp_c,
  // Output pins
  output logic general_output_a_out,
  output logic general_output_a_oe,
  output logic general_output_b_out,
  output logic general_output_b_oe,
  output logic general_output_c_out,
  output logic general_output_c_oe,
  // Analog configuration
  output logic clock_input_pulldown,
  output logic enable_one_pulldown,
  output logic enable_two_pulldown,
  output logic enable_three_pulldown,
  output logic spread_spectrum_enable,
  output logic thermal_warning,
  // Clock synchronisation
  output logic use_external_clock,
  output logic [4:0] external_clock_frequency_code,
  output logic clock_change_event,
  // Delayed rail enable
  input wire logic rail_request,
  input wire logic [3:0] startup_code,
  input wire logic [3:0] shutdown_code,
  output logic rail_on
);
  import opc_pkg::*;

  logic [7:0] control_a_ff, control_b_ff, config_ff, clock_sync_ff;
  logic [2:0] en_meta_ff, en_sync_ff;
  logic [2:0] clk_pipe_ff;
  logic [8:0] since_edge_ff;
  logic clock_present_ff, use_ext_ff, present_last_ff;
  logic event_ff;
  opc_seq_e seq_ff, nxt_seq;
  logic [3:0] steps_ff;
  logic [22:0] tick_ff;
  logic step_done;

  // Step length in cycles for the chosen range
  function automatic logic [22:0] step_len(input logic long_range);
    step_len = long_range ? 23'(2 * STEP_CYCLES) : 23'(STEP_CYCLES);
  endfunction : step_len

  // Registers load OTP defaults, never hardwired values
  always_ff @(posedge clock) begin
    if (reset) begin
      control_a_ff <= otp_control_a;
      control_b_ff <= otp_control_b;
      config_ff <= otp_config;
      clock_sync_ff <= otp_clock_sync;
    end else if (reg_write) begin
      unique case (reg_address)
        OFS_CONTROL_A: control_a_ff <= reg_write_data;
        OFS_CONTROL_B: control_b_ff <= reg_write_data;
        OFS_CONFIG: config_ff <= reg_write_data;
        OFS_CLOCK_SYNC: clock_sync_ff <= reg_write_data;
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read zero
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_data <= 8'h00;
      reg_read_valid <= 1'b0;
    end else begin
      reg_read_valid <= reg_read;
      if (reg_read) begin
        unique case (reg_address)
          OFS_CONTROL_A: reg_read_data <= control_a_ff;
          OFS_CONTROL_B: reg_read_data <= control_b_ff;
          OFS_CONFIG: reg_read_data <= config_ff;
          OFS_CLOCK_SYNC: reg_read_data <= clock_sync_ff;
          default: reg_read_data <= 8'h00;
        endcase
      end
    end
  end

  // Two-flop synchronisers for the enable pins
  always_ff @(posedge clock) begin
    if (reset) begin
      en_meta_ff <= 3'h0;
      en_sync_ff <= 3'h0;
    end else begin
      en_meta_ff <= {enable_input_three, enable_input_two,
                     enable_input_one};
      en_sync_ff <= en_meta_ff;
    end
  end

  // Output A: no alternate function
  opc_pin_cell u_cell_a (
    .clock(clock),
    .reset(reset),
    .gate_select(control_a_ff[A_GATE_HI:A_GATE_LO]),
    .level(control_a_ff[A_LEVEL]),
    .open_drain(control_a_ff[A_DRIVE_TYPE]),
    .func_is_output(1'b1),
    .alt_drive(1'b0),
    .alt_level(1'b0),
    .enables(en_sync_ff),
    .pin_out(general_output_a_out),
    .pin_oe(general_output_a_oe)
  );

  // Output B shares its pin with power-good; drive type covers both
  opc_pin_cell u_cell_b (
    .clock(clock),
    .reset(reset),
    .gate_select(control_a_ff[B_GATE_HI:B_GATE_LO]),
    .level(control_a_ff[B_LEVEL]),
    .open_drain(control_a_ff[B_DRIVE_TYPE]),
    .func_is_output(control_b_ff[PG_PIN_FUNC]),
    .alt_drive(1'b1),
    .alt_level(power_good_b),
    .enables(en_sync_ff),
    .pin_out(general_output_b_out),
    .pin_oe(general_output_b_oe)
  );

  // Output C shares its pin with the clock input, released as input
  opc_pin_cell u_cell_c (
    .clock(clock),
    .reset(reset),
    .gate_select(control_b_ff[C_GATE_HI:C_GATE_LO]),
    .level(control_b_ff[C_LEVEL]),
    .open_drain(control_b_ff[C_DRIVE_TYPE]),
    .func_is_output(control_b_ff[CLOCK_PIN_FUNC]),
    .alt_drive(1'b0),
    .alt_level(1'b0),
    .enables(en_sync_ff),
    .pin_out(general_output_c_out),
    .pin_oe(general_output_c_oe)
  );

  // Configuration outputs are flops, not decoded from the bus
  always_ff @(posedge clock) begin
    if (reset) begin
      clock_input_pulldown <= 1'b0;
      enable_one_pulldown <= 1'b0;
      enable_two_pulldown <= 1'b0;
      enable_three_pulldown <= 1'b0;
      spread_spectrum_enable <= 1'b0;
      thermal_warning <= 1'b0;
      external_clock_frequency_code <= 5'h00;
    end else begin
      clock_input_pulldown <= config_ff[CLOCK_PD];
      enable_three_pulldown <= config_ff[PD_ENABLE_THREE];
      enable_two_pulldown <= config_ff[PD_ENABLE_TWO];
      enable_one_pulldown <= config_ff[PD_ENABLE_ONE];
      spread_spectrum_enable <= config_ff[SPREAD_ENABLE];
      thermal_warning <= die_temp_c >= (config_ff[THERMAL_LEVEL] ?
        THERMAL_HIGH_C : THERMAL_LOW_C);
      // Passed straight on: the host keeps it still while looping
      external_clock_frequency_code <= clock_sync_ff[FREQ_HI:FREQ_LO];
    end
  end

  // External clock presence: an edge within the loss window
  always_ff @(posedge clock) begin
    if (reset) begin
      clk_pipe_ff <= 3'h0;
      since_edge_ff <= 9'h000;
      clock_present_ff <= 1'b0;
    end else begin
      clk_pipe_ff <= {clk_pipe_ff[1:0], external_clock_input};
      if (clk_pipe_ff[2] != clk_pipe_ff[1]) begin
        since_edge_ff <= 9'h000;
        clock_present_ff <= 1'b1;
      end else if (since_edge_ff == 9'(CLOCK_LOSS_CYCLES - 1)) begin
        clock_present_ff <= 1'b0;
      end else begin
        since_edge_ff <= since_edge_ff + 9'h001;
      end
    end
  end

  // Loop off forces the internal oscillator; clock presence changes raise a pulse while looping
  always_ff @(posedge clock) begin
    if (reset) begin
      use_ext_ff <= 1'b0;
      event_ff <= 1'b0;
      present_last_ff <= 1'b0;
    end else begin
      use_ext_ff <= clock_sync_ff[LOOP_ENABLE] & clock_present_ff;
      event_ff <= clock_sync_ff[LOOP_ENABLE] &
                  (clock_present_ff != present_last_ff);
      present_last_ff <= clock_present_ff;
    end
  end
  assign use_external_clock = use_ext_ff;
  assign clock_change_event = event_ff;

  // Delayed enable: code counts whole steps after the request edge
  assign step_done = tick_ff == 23'h000000;
  always_comb begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      SEQ_OFF: if (rail_request) nxt_seq = SEQ_RISING;
      SEQ_RISING: begin
        if (!rail_request) nxt_seq = SEQ_OFF;
        else if (steps_ff == 4'h0) nxt_seq = SEQ_ON;
      end
      SEQ_ON: if (!rail_request) nxt_seq = SEQ_FALLING;
      SEQ_FALLING: begin
        if (rail_request) nxt_seq = SEQ_ON;
        else if (steps_ff == 4'h0) nxt_seq = SEQ_OFF;
      end
    endcase
  end

  // Step timer and remaining step count
  always_ff @(posedge clock) begin
    if (reset) begin
      seq_ff <= SEQ_OFF;
      steps_ff <= 4'h0;
      tick_ff <= 23'h000000;
    end else begin
      seq_ff <= nxt_seq;
      if (seq_ff == SEQ_OFF && rail_request) begin
        steps_ff <= startup_code;
        tick_ff <= step_len(config_ff[STARTUP_RANGE]) - 23'h1;
      end else if (seq_ff == SEQ_ON && !rail_request) begin
        steps_ff <= shutdown_code;
        tick_ff <= step_len(config_ff[SHUTDOWN_RANGE]) - 23'h1;
      end else if (steps_ff != 4'h0) begin
        if (step_done) begin
          steps_ff <= steps_ff - 4'h1;
          tick_ff <= step_len(seq_ff == SEQ_FALLING ?
            config_ff[SHUTDOWN_RANGE] : config_ff[STARTUP_RANGE]) - 23'h1;
        end else begin
          tick_ff <= tick_ff - 23'h1;
        end
      end
    end
  end
  assign rail_on = (seq_ff == SEQ_ON) || (seq_ff == SEQ_FALLING);

  // Checks; sampled reset keeps the release edge out of the antecedents
  a_b_open_drain: assert property (@(posedge clock) disable iff (reset)
    control_a_ff[B_DRIVE_TYPE] ##1 control_a_ff[B_DRIVE_TYPE]
    |-> !general_output_b_out)
    else $error("output B drove high in open-drain mode");
  a_b_gate_one: assert property (@(posedge clock) disable iff (reset)
    (control_b_ff[PG_PIN_FUNC] && !control_a_ff[B_DRIVE_TYPE] &&
     control_a_ff[B_GATE_HI:B_GATE_LO] == 2'h1 &&
     control_a_ff[B_LEVEL] && !enable_input_one)[*4]
    |-> !general_output_b_out)
    else $error("output B not gated by enable one");
  a_b_pg_func: assert property (@(posedge clock) disable iff (reset)
    (!reset && !control_b_ff[PG_PIN_FUNC] && !control_a_ff[B_DRIVE_TYPE])[*2]
    |-> general_output_b_out == $past(power_good_b))
    else $error("power-good not on shared pin");
  a_a_level_copy: assert property (@(posedge clock) disable iff (reset)
    (!reset && !control_a_ff[A_DRIVE_TYPE] &&
     control_a_ff[A_GATE_HI:A_GATE_LO] == 2'h0)[*2]
    |-> general_output_a_out == $past(control_a_ff[A_LEVEL]))
    else $error("output A level not followed");
  a_a_push_pull: assert property (@(posedge clock) disable iff (reset)
    !reset && !control_a_ff[A_DRIVE_TYPE] |=> general_output_a_oe)
    else $error("output A not driven in push-pull");
  a_a_gate_three: assert property (@(posedge clock) disable iff (reset)
    (control_a_ff[A_GATE_HI:A_GATE_LO] == 2'h3 && control_a_ff[A_LEVEL]
     && !control_a_ff[A_DRIVE_TYPE] && enable_input_three)[*4]
    |-> general_output_a_out)
    else $error("output A not passed by enable three");
  a_c_released: assert property (@(posedge clock) disable iff (reset)
    !control_b_ff[CLOCK_PIN_FUNC] |=> !general_output_c_oe)
    else $error("clock pin driven while an input");
  a_c_level: assert property (@(posedge clock) disable iff (reset)
    (!reset && control_b_ff[CLOCK_PIN_FUNC] && control_b_ff[C_DRIVE_TYPE] &&
     control_b_ff[C_GATE_HI:C_GATE_LO] == 2'h0)[*2]
    |-> general_output_c_oe == !$past(control_b_ff[C_LEVEL]))
    else $error("output C open-drain level wrong");
  a_loop_off: assert property (@(posedge clock) disable iff (reset)
    !clock_sync_ff[LOOP_ENABLE] |=> !use_external_clock)
    else $error("external clock used with loop off");
  a_pulldown_map: assert property (@(posedge clock) disable iff (reset)
    !reset |=> enable_three_pulldown == $past(config_ff[PD_ENABLE_THREE]))
    else $error("enable three pull-down mismatch");
  a_spread_map: assert property (@(posedge clock) disable iff (reset)
    !reset |=> spread_spectrum_enable == $past(config_ff[SPREAD_ENABLE]))
    else $error("spread-spectrum enable mismatch");
  a_thermal_low: assert property (@(posedge clock) disable iff (reset)
    !reset && !config_ff[THERMAL_LEVEL] && die_temp_c == THERMAL_LOW_C
    |=> thermal_warning)
    else $error("thermal warning missed at low threshold");
  a_zero_delay: assert property (@(posedge clock) disable iff (reset)
    !reset && seq_ff == SEQ_OFF && rail_request && startup_code == 4'h0
    ##1 rail_request |=> rail_on)
    else $error("zero startup delay not immediate");
  a_read_back: assert property (@(posedge clock) disable iff (reset)
    reg_read && reg_address == OFS_CONFIG
    |=> reg_read_valid && reg_read_data == $past(config_ff))
    else $error("register read-back mismatch");

  c_b_as_output: cover property (@(posedge clock) disable iff (reset)
    control_b_ff[PG_PIN_FUNC] && general_output_b_oe);
  c_ext_clock: cover property (@(posedge clock) disable iff (reset)
    use_external_clock);
  c_clock_event: cover property (@(posedge clock) disable iff (reset)
    clock_change_event);
  c_rail_cycle: cover property (@(posedge clock) disable iff (reset)
    seq_ff == SEQ_FALLING ##1 seq_ff == SEQ_OFF);
endmodule : opc_regs

//--- testbench/opc_pin_partner.sv
/*
  Far-side model of the pin drivers: the three enable pin drivers and
  the external clock source. Assumes the bench sets the pattern and
  the run flag just after its own clock edges.
*/
`timescale 1ns/1ps
module opc_pin_partner (
  // Bench controls
  input wire logic [2:0] en_pattern,
  input wire logic clk_run,
  // Pins toward the block
  output logic enable_input_one,
  output logic enable_input_two,
  output logic enable_input_three,
  output logic external_clock_input
);
  // Enable drivers follow the pattern, bit 0 is enable one
  assign enable_input_one = en_pattern[0];
  assign enable_input_two = en_pattern[1];
  assign enable_input_three = en_pattern[2];
  // Clock source of 14 ns period, unrelated to the core clock; held low
  // while stopped, where the enabled pull-down would leave the pin
  initial begin
    external_clock_input = 1'b0;
    forever #7 external_clock_input = clk_run & ~external_clock_input;
  end
endmodule : opc_pin_partner

//--- testbench/output_pin_and_config_regs_bench.sv
/*
  Self-checking bench for the output pin and configuration registers.
  Assumes the design package and the pin driver model beside it.
*/
`timescale 1ns/1ps
module output_pin_and_config_regs_bench;
  import opc_pkg::*;
  localparam int STEP = 4;
  logic clock, reset, reg_write, reg_read, reg_read_valid;
  logic [7:0] reg_address, reg_write_data, reg_read_data, die_temp_c;
  logic [7:0] v, ca, cb;
  logic [7:0] otp [4];
  logic power_good_b, rail_request, rail_on, clk_run, o, l;
  logic [3:0] startup_code, shutdown_code;
  logic [2:0] en_pattern, pin_out, pin_oe, oh;
  logic en_one, en_two, en_three, ext_clk, pd_clk, pd1, pd2, pd3;
  logic spread, warn, use_ext, chg_evt, w;
  logic [4:0] freq_code;
  logic [1:0] gg;
  int fail_count, samples_checked, cycles, n;

  // Design with a short delay step so sequencer runs stay brief
  opc_regs #(.STEP_CYCLES(STEP)) opc_regs_inst (
    .clock(clock), .reset(reset), .reg_write(reg_write),
    .reg_read(reg_read), .reg_address(reg_address),
    .reg_write_data(reg_write_data), .reg_read_data(reg_read_data),
    .reg_read_valid(reg_read_valid), .otp_control_a(otp[0]),
    .otp_control_b(otp[1]), .otp_config(otp[2]),
    .otp_clock_sync(otp[3]), .enable_input_one(en_one),
    .enable_input_two(en_two), .enable_input_three(en_three),
    .external_clock_input(ext_clk), .power_good_b(power_good_b),
    .die_temp_c(die_temp_c), .general_output_a_out(pin_out[0]),
    .general_output_a_oe(pin_oe[0]), .general_output_b_out(pin_out[1]),
    .general_output_b_oe(pin_oe[1]), .general_output_c_out(pin_out[2]),
    .general_output_c_oe(pin_oe[2]), .clock_input_pulldown(pd_clk),
    .enable_one_pulldown(pd1), .enable_two_pulldown(pd2),
    .enable_three_pulldown(pd3), .spread_spectrum_enable(spread),
    .thermal_warning(warn), .use_external_clock(use_ext),
    .external_clock_frequency_code(freq_code),
    .clock_change_event(chg_evt), .rail_request(rail_request),
    .startup_code(startup_code), .shutdown_code(shutdown_code),
    .rail_on(rail_on)
  );

  // Far-side pin drivers
  opc_pin_partner opc_pin_partner_inst (
    .en_pattern(en_pattern), .clk_run(clk_run),
    .enable_input_one(en_one), .enable_input_two(en_two),
    .enable_input_three(en_three), .external_clock_input(ext_clk)
  );

  // Core clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", fail_count,
             samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // Byte write: strobe held for exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_address <= a;
    reg_write_data <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  // Byte read: waits a bounded time for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int k;
    @(posedge clock);
    reg_read <= 1'b1;
    reg_address <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    k = 0;
    while (reg_read_valid !== 1'b1 && k < 8) begin
      @(posedge clock);
      k++;
    end
    d = (k < 8) ? reg_read_data : 8'hxx;
  endtask : rd

  task automatic do_reset();
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
  endtask : do_reset

  // Hang guard; the whole run needs well under 6000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    {reset, reg_write, reg_read, power_good_b, rail_request} = 5'h10;
    {reg_address, reg_write_data, die_temp_c} = 24'h0;
    {startup_code, shutdown_code, en_pattern, clk_run} = 12'h0;
    otp = '{RST_CONTROL_A, RST_CONTROL_B, RST_CONFIG, RST_CLOCK_SYNC};
    do_reset();
    // Defaults and pull-down outputs once the release edge has passed
    repeat (2) @(posedge clock);
    check({pd_clk, pd3, pd2, pd1, spread}, 8'h1e);
    for (int i = 0; i < 4; i++) begin
      rd(OFS_CONTROL_A + 8'(i), v);
      check(v, otp[i]);
    end
    // Different OTP contents must show up after a second reset
    otp <= '{8'h55, 8'hc3, 8'h81, 8'h1f};
    do_reset();
    for (int i = 0; i < 4; i++) begin
      rd(OFS_CONTROL_A + 8'(i), v);
      check(v, otp[i]);
    end
    // Unmapped places take no write and read as zero; reserved bits store
    wr(8'h13, 8'hff);
    rd(8'h13, v);
    check(v, 8'h00);
    wr(OFS_CONTROL_B, 8'hc0);
    rd(OFS_CONTROL_B, v);
    check(v, 8'hc0);
    // One configuration bit at a time against the analog outputs
    for (int i = 0; i < 6; i++) begin
      v = 8'h01 << i;
      wr(OFS_CONFIG, v);
      repeat (3) @(posedge clock);
      check({pd_clk, pd3, pd2, pd1, spread}, {v[5:2], v[0]});
    end
    // Thermal warning just below and at each threshold
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CONFIG, s ? 8'h3e : 8'h3c);
      for (int d = 0; d < 2; d++) begin
        die_temp_c <= (s ? 8'h8b : 8'h7c) + 8'(d);
        repeat (3) @(posedge clock);
        check(warn, d[0]);
      end
    end
    // Every pin, gate code, drive type and level, selected enable on/off
    for (int p = 0; p < 3; p++) begin
      for (int g = 0; g < 4; g++) begin
        for (int m = 0; m < 4; m++) begin
          gg = g[1:0];
          o = m[1];
          l = m[0];
          oh = (g == 0) ? 3'h0 : 3'h1 << (g - 1);
          ca = (p == 0) ? {4'h0, o, gg, l} : (p == 1) ? {o, gg, l, 4'h0}
             : 8'h00;
          cb = (p == 0) ? 8'h00 : (p == 1) ? 8'h10 : {4'h3, o, gg, l};
          wr(OFS_CONTROL_A, ca);
          wr(OFS_CONTROL_B, cb);
          for (int k = 0; k < 2; k++) begin
            en_pattern <= k ? ~oh : oh;
            power_good_b <= k[0];
            repeat (5) @(posedge clock);
            w = l & ((g == 0) | (k == 0));
            check(pin_out[p], o ? 1'b0 : w);
            check(pin_oe[p], o ? !w : 1'b1);
            if (p == 0) check(pin_out[1], k[0]);
            if (p != 2) check(pin_oe[2], 1'b0);
          end
        end
      end
    end
    // Startup and shutdown delays in both step ranges
    for (int s = 0; s < 2; s++) begin
      wr(OFS_CONFIG, s ? 8'hfc : 8'h3c);
      n = 3 * STEP * (s + 1);
      startup_code <= 4'h3;
      shutdown_code <= 4'h3;
      rail_request <= 1'b1;
      repeat (n - 1) @(posedge clock);
      check(rail_on, 1'b0);
      repeat (6) @(posedge clock);
      check(rail_on, 1'b1);
      rail_request <= 1'b0;
      repeat (n - 1) @(posedge clock);
      check(rail_on, 1'b1);
      repeat (6) @(posedge clock);
      check(rail_on, 1'b0);
    end
    // Zero codes switch the rail on and off almost at once
    startup_code <= 4'h0;
    shutdown_code <= 4'h0;
    rail_request <= 1'b1;
    repeat (3) @(posedge clock);
    check(rail_on, 1'b1);
    rail_request <= 1'b0;
    repeat (3) @(posedge clock);
    check(rail_on, 1'b0);
    // Frequency code set with the loop off, then the loop turned on
    clk_run <= 1'b1;
    wr(OFS_CLOCK_SYNC, 8'h0b);
    repeat (20) @(posedge clock);
    check(use_ext, 1'b0);
    wr(OFS_CLOCK_SYNC, 8'h4b);
    repeat (20) @(posedge clock);
    check(use_ext, 1'b1);
    check(freq_code, 5'h0b);
    // Losing the clock while looping flags exactly one change
    clk_run <= 1'b0;
    n = 0;
    repeat (600) begin
      @(posedge clock);
      if (chg_evt === 1'b1) n++;
    end
    check(8'(n), 8'h01);
    check(use_ext, 1'b0);
    // The clock coming back while looping flags one change as well
    clk_run <= 1'b1;
    n = 0;
    repeat (40) begin
      @(posedge clock);
      if (chg_evt === 1'b1) n++;
    end
    check(8'(n), 8'h01);
    check(use_ext, 1'b1);
    close_out();
  end
endmodule : output_pin_and_config_regs_bench
